// ---- fr_seq_pkg.sv ----
// constants, register map and carrier types of the fundamental reset sequencer
// assumes one 100 MHz core clock and a byte-addressed 32-bit register port
package fr_seq_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_BUS_STAT = 8'h08;
  localparam logic [7:0] OFS_EEP_WIN = 8'h0C;
  localparam logic [7:0] OFS_EEP_DATA = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_FUNDAMENTAL_RESET_REQUEST_BIT = 1;
  localparam int STAT_HALT_BIT = 0;
  localparam int STAT_SLOW_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_MODE_LSB = 4;
  localparam int BUS_DONE_BIT = 0;
  localparam int BUS_ERR_BIT = 1;
  localparam int BUS_TMO_BIT = 2;
  localparam int BUS_CNT_LSB = 8;
  localparam int WIN_GO_BIT = 31;
  localparam int WIN_ERR_BIT = 30;
  localparam int EV_DONE = 0;
  localparam int EV_ERR = 1;
  localparam int EV_HALT = 2;
  localparam int EV_RUN = 3;
  localparam int EV_W = 4;
  // ----------------------------------------------------------------
  // reset values, modes and timing
  // ----------------------------------------------------------------
  localparam logic [EV_W-1:0] INT_MASK_RST = 4'h0;
  localparam logic [3:0] MODE_EEPROM = 4'h1;
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_KHZ = 100;
  localparam int FAST_KHZ = 400;
  localparam int SLOW_DIV = CLK_HZ / (SLOW_KHZ * 1000);
  localparam int FAST_DIV = CLK_HZ / (FAST_KHZ * 1000);
  localparam int LOAD_BUDGET_MS = 200;
  localparam int LOAD_BUDGET_CYC = LOAD_BUDGET_MS * (CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic last;
    logic [7:0] addr;
    logic [31:0] data;
  } eep_rec_t;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
  } cfg_wr_t;
endpackage

// ---- fundamental_reset_init_sequencer.sv ----
// fundamental reset sequencer: bus bring-up, eeprom load, reset-halt, warm reset
// assumes synchronous pins, a one-cycle register port and an eeprom read agent
`timescale 1ns/1ps
`default_nettype none
module fundamental_reset_init_sequencer
  import fr_seq_pkg::*;
#(
  parameter int LOAD_CYC = LOAD_BUDGET_CYC
) (
  input wire logic sys_clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic bus_reset_input_n, // fundamental reset pin
  input wire logic [3:0] operating_mode_pins, // boot mode straps
  input wire logic controller_bus_slow_select, // slow controller bus strap
  input wire logic [5:0] target_bus_address_pins, // target bus address straps
  input wire logic reset_halt_pin, // reset-halt strap
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  output logic eep_req, // eeprom read request, held to ack
  output logic [15:0] eep_addr, // eeprom record address
  input wire eep_rec_t eep_rec, // returned record
  input wire logic eep_ack, // read finished pulse
  input wire logic eep_err, // read failed, with ack
  output logic [15:0] ctrl_bus_div, // controller bus clock period
  output logic ctrl_bus_rst_n, // controller bus reset
  output logic target_bus_rst_n, // target bus reset
  output logic [3:0] target_bus_addr, // target bus own address
  output cfg_wr_t cfg_wr, // loaded register write
  output logic core_rst_n, // reset of the rest of the device
  output logic retry_mode, // stacks answer retry
  output logic normal_op, // normal operation
  output logic warm_reset, // warm reset pulse
  output logic irq // interrupt level
);
  typedef enum logic [2:0] {
    ST_WAIT, ST_TGT, ST_CTL, ST_LREQ, ST_LWAIT, ST_CHK, ST_HALT, ST_RUN
  } state_t;

  state_t state, next_state;
  logic prn_q, warm_go, fundamental_reset_request_pend;
  logic [3:0] smp_mode;
  logic smp_slow, smp_halt;
  logic [5:0] smp_addr;
  logic ctrl_halt, stat_halt;
  logic bus_done, bus_err, bus_tmo;
  logic [7:0] bus_cnt;
  logic [15:0] ld_ptr;
  logic [31:0] ld_timer;
  logic win_busy, win_err;
  logic [31:0] win_data;
  logic [EV_W-1:0] int_stat, int_mask;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire prn_rise = bus_reset_input_n & ~prn_q;
  wire wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
  wire wr_win = reg_wr && reg_addr == OFS_EEP_WIN;
  wire wr_istat = reg_wr && reg_addr == OFS_INT_STAT;
  wire wr_imask = reg_wr && reg_addr == OFS_INT_MASK;
  wire fundamental_reset_request_req = wr_ctrl & reg_wdata[CTRL_FUNDAMENTAL_RESET_REQUEST_BIT];
  wire ld_ack = state == ST_LWAIT && eep_ack;
  wire ld_fail = ld_ack & eep_err;
  wire ld_good = ld_ack & ~eep_err;
  wire ld_tmo = state == ST_LWAIT && !eep_ack && ld_timer >= 32'(LOAD_CYC - 1);
  wire ld_abort = ld_fail | ld_tmo;
  wire ld_finish = ld_good & eep_rec.last;
  wire ld_ctrl = ld_good && eep_rec.addr == OFS_CTRL;
  wire enter_seq = state == ST_WAIT && bus_reset_input_n && (prn_rise || warm_go);
  wire win_start = wr_win && reg_wdata[WIN_GO_BIT] && state == ST_HALT && !win_busy;
  wire win_ack = state == ST_HALT && win_busy && eep_ack;
  wire pin_halt = state == ST_TGT && smp_halt;
  wire halt_evt = next_state == ST_HALT && state != ST_HALT;
  wire run_evt = next_state == ST_RUN && state != ST_RUN;
  wire [EV_W-1:0] events = {run_evt, halt_evt, ld_abort, ld_finish | ld_abort};
  wire [EV_W-1:0] next_int_stat = (int_stat & ~(wr_istat ? reg_wdata[EV_W-1:0] : '0))
                                  | events;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT: begin
        if (enter_seq) begin
          next_state = ST_TGT;
        end
      end
      ST_TGT: next_state = ST_CTL;
      ST_CTL: begin
        next_state = (smp_mode == MODE_EEPROM) ? ST_LREQ : ST_CHK;
      end
      ST_LREQ: next_state = ST_LWAIT;
      ST_LWAIT: begin
        if (ld_abort || ld_finish) begin
          next_state = ST_CHK;
        end else if (ld_good) begin
          next_state = ST_LREQ;
        end
      end
      ST_CHK: next_state = ctrl_halt ? ST_HALT : ST_RUN;
      ST_HALT: begin
        if (!ctrl_halt && !win_busy) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_WAIT;
    endcase
    // the pin and a requested warm reset both restart the whole sequence
    if (!bus_reset_input_n || fundamental_reset_request_pend) begin
      next_state = ST_WAIT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_WAIT;
      prn_q <= 1'b0;
    end else begin
      state <= next_state;
      prn_q <= bus_reset_input_n;
    end
  end

  // ----------------------------------------------------------------
  // boot straps
  // ----------------------------------------------------------------
  // a requested warm reset leaves these untouched, so its pass reuses them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      smp_mode <= 4'h0;
      smp_slow <= 1'b0;
      smp_addr <= 6'h00;
      smp_halt <= 1'b0;
    end else if (state == ST_WAIT && prn_rise) begin
      smp_mode <= operating_mode_pins;
      smp_slow <= controller_bus_slow_select;
      smp_addr <= target_bus_address_pins;
      smp_halt <= reset_halt_pin;
    end
  end

  // ----------------------------------------------------------------
  // warm reset request
  // ----------------------------------------------------------------
  // the write itself never stalls, so its completion is out before the pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fundamental_reset_request_pend <= 1'b0;
      warm_reset <= 1'b0;
      warm_go <= 1'b0;
    end else begin
      fundamental_reset_request_pend <= fundamental_reset_request_req;
      warm_reset <= fundamental_reset_request_pend;
      if (fundamental_reset_request_pend) begin
        warm_go <= 1'b1;
      end else if (state != ST_WAIT) begin
        warm_go <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus bring-up
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_bus_div <= 16'(FAST_DIV);
      target_bus_rst_n <= 1'b0;
      ctrl_bus_rst_n <= 1'b0;
      target_bus_addr <= 4'h0;
    end else if (next_state == ST_WAIT) begin
      target_bus_rst_n <= 1'b0;
      ctrl_bus_rst_n <= 1'b0;
    end else if (state == ST_TGT) begin
      // straps land on the release edge, so they can only be used one cycle later
      ctrl_bus_div <= smp_slow ? 16'(SLOW_DIV) : 16'(FAST_DIV);
      target_bus_addr <= {smp_addr[5], smp_addr[3:1]};
      target_bus_rst_n <= 1'b1;
    end else if (state == ST_CTL) begin
      ctrl_bus_rst_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // eeprom load and access window
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || state == ST_WAIT) begin
      eep_req <= 1'b0;
      eep_addr <= 16'h0000;
      ld_ptr <= 16'h0000;
      ld_timer <= 32'h0000_0000;
      win_busy <= 1'b0;
    end else begin
      if (state == ST_LREQ) begin
        eep_req <= 1'b1;
        eep_addr <= ld_ptr;
      end else if (win_start) begin
        eep_req <= 1'b1;
        eep_addr <= reg_wdata[15:0];
      end else if (eep_ack || ld_tmo) begin
        eep_req <= 1'b0;
      end
      if (ld_good) begin
        ld_ptr <= ld_ptr + 16'h0001;
      end
      if (state == ST_LREQ || state == ST_LWAIT) begin
        ld_timer <= ld_timer + 32'h0000_0001;
      end
      if (win_start) begin
        win_busy <= 1'b1;
      end else if (win_ack) begin
        win_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      win_data <= 32'h0000_0000;
      win_err <= 1'b0;
    end else if (win_ack) begin
      win_data <= eep_rec.data;
      win_err <= eep_err;
    end
  end

  // each record is written out the cycle after it lands, so its side effect starts one cycle later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_wr <= '0;
    end else begin
      cfg_wr.valid <= ld_good;
      cfg_wr.addr <= eep_rec.addr;
      cfg_wr.data <= eep_rec.data;
    end
  end

  // ----------------------------------------------------------------
  // control, status and bus status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_halt <= 1'b0;
      stat_halt <= 1'b0;
    end else begin
      if (ld_abort || pin_halt) begin
        ctrl_halt <= 1'b1;
      end else if (ld_ctrl) begin
        ctrl_halt <= eep_rec.data[CTRL_HALT_BIT];
      end else if (wr_ctrl) begin
        ctrl_halt <= reg_wdata[CTRL_HALT_BIT];
      end
      if (pin_halt) begin
        stat_halt <= 1'b1;
      end else if (enter_seq) begin
        stat_halt <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || enter_seq) begin
      bus_done <= 1'b0;
      bus_err <= 1'b0;
      bus_tmo <= 1'b0;
      bus_cnt <= 8'h00;
    end else begin
      if (ld_finish || ld_abort) begin
        bus_done <= 1'b1;
      end
      if (ld_fail) begin
        bus_err <= 1'b1;
      end
      if (ld_tmo) begin
        bus_tmo <= 1'b1;
      end
      if (ld_good) begin
        bus_cnt <= bus_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // device-wide reset and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_rst_n <= 1'b0;
      retry_mode <= 1'b0;
      normal_op <= 1'b0;
      int_stat <= '0;
      int_mask <= INT_MASK_RST;
      irq <= 1'b0;
    end else begin
      core_rst_n <= next_state == ST_RUN;
      retry_mode <= next_state != ST_RUN && next_state != ST_WAIT;
      normal_op <= next_state == ST_RUN;
      int_stat <= next_int_stat;
      if (wr_imask) begin
        int_mask <= reg_wdata[EV_W-1:0];
      end
      irq <= |(next_int_stat & (wr_imask ? reg_wdata[EV_W-1:0] : int_mask));
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      OFS_CTRL: rd_mux[CTRL_HALT_BIT] = ctrl_halt;
      OFS_STAT: begin
        rd_mux[STAT_HALT_BIT] = stat_halt;
        rd_mux[STAT_SLOW_BIT] = smp_slow;
        rd_mux[STAT_RUN_BIT] = normal_op;
        rd_mux[STAT_MODE_LSB +: 4] = smp_mode;
      end
      OFS_BUS_STAT: begin
        rd_mux[BUS_DONE_BIT] = bus_done;
        rd_mux[BUS_ERR_BIT] = bus_err;
        rd_mux[BUS_TMO_BIT] = bus_tmo;
        rd_mux[BUS_CNT_LSB +: 8] = bus_cnt;
      end
      OFS_EEP_WIN: begin
        rd_mux[WIN_GO_BIT] = win_busy;
        rd_mux[WIN_ERR_BIT] = win_err;
        rd_mux[15:0] = eep_addr;
      end
      OFS_EEP_DATA: rd_mux = win_data;
      OFS_INT_STAT: rd_mux[EV_W-1:0] = int_stat;
      OFS_INT_MASK: rd_mux[EV_W-1:0] = int_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
endmodule // fundamental_reset_init_sequencer
`default_nettype wire

// ---- fr_seq_monitor.sv ----
// checker of sequencer outputs against its strap and eeprom inputs
// assumes it is bound into the sequencer top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fr_seq_monitor
  import fr_seq_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic rst, // reset
  input wire logic bus_reset_input_n, // reset pin
  input wire logic controller_bus_slow_select, // speed strap
  input wire logic [5:0] target_bus_address_pins, // address straps
  input wire logic eep_ack, // eeprom done
  input wire logic [15:0] ctrl_bus_div, // bus period
  input wire logic ctrl_bus_rst_n, // controller bus reset
  input wire logic target_bus_rst_n, // target bus reset
  input wire logic [3:0] target_bus_addr, // own address
  input wire cfg_wr_t cfg_wr, // loaded write
  input wire logic core_rst_n, // core reset
  input wire logic retry_mode, // retry answers
  input wire logic normal_op, // running
  input wire logic warm_reset // warm pulse
);
  logic pin_q;
  logic slow_q;
  logic [3:0] adr_q;
  // straps latch on pin release only, so a requested reset keeps them
  always_ff @(posedge sys_clk) begin
    pin_q <= rst ? 1'b0 : bus_reset_input_n;
    if (!rst && bus_reset_input_n && !pin_q) begin
      slow_q <= controller_bus_slow_select;
      adr_q <= {target_bus_address_pins[5], target_bus_address_pins[3:1]};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_speed_from_strap: assert property (
    $rose(target_bus_rst_n) |-> ctrl_bus_div == (slow_q ? 16'h03E8 : 16'h00FA))
    else $error("controller bus period wrong");
  a_own_address: assert property (
    $rose(target_bus_rst_n) |-> target_bus_addr == adr_q) else $error("target address wrong");
  a_ctrl_after_tgt: assert property (
    $rose(ctrl_bus_rst_n) |-> $past(target_bus_rst_n)) else $error("controller bus too early");
  a_ctrl_needs_tgt: assert property (
    ctrl_bus_rst_n |-> target_bus_rst_n) else $error("controller bus up alone");
  a_cfg_on_ack: assert property (
    cfg_wr.valid |-> $past(eep_ack)) else $error("loaded write without record");
  a_retry_in_reset: assert property (
    retry_mode |-> !core_rst_n && !normal_op) else $error("retry while running");
  a_run_state: assert property (
    normal_op |-> core_rst_n && ctrl_bus_rst_n && target_bus_rst_n) else $error("bad run state");
  a_warm_stops: assert property (
    warm_reset |=> !warm_reset && !normal_op) else $error("warm reset not taken");
  a_pin_stops: assert property (
    !bus_reset_input_n |-> ##2 !normal_op) else $error("running under pin reset");
endmodule // fr_seq_monitor
bind fundamental_reset_init_sequencer fr_seq_monitor fr_seq_monitor_inst (
  .sys_clk(sys_clk), .rst(rst), .bus_reset_input_n(bus_reset_input_n),
  .controller_bus_slow_select(controller_bus_slow_select),
  .target_bus_address_pins(target_bus_address_pins), .eep_ack(eep_ack),
  .ctrl_bus_div(ctrl_bus_div), .ctrl_bus_rst_n(ctrl_bus_rst_n),
  .target_bus_rst_n(target_bus_rst_n), .target_bus_addr(target_bus_addr), .cfg_wr(cfg_wr),
  .core_rst_n(core_rst_n), .retry_mode(retry_mode), .normal_op(normal_op),
  .warm_reset(warm_reset));
`default_nettype wire

// ---- eep_model.sv ----
// eeprom read agent: answers each held request after a set delay
// assumes the requester holds eep_req until the cycle after eep_ack
`timescale 1ns/1ps
`default_nettype none
module eep_model
  import fr_seq_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic rst, // reset
  input wire logic eep_req, // read request
  input wire logic [15:0] eep_addr, // record address
  input wire logic [3:0] dly, // answer delay
  input wire logic [15:0] last_idx, // final record
  input wire logic [15:0] err_idx, // failing record
  output eep_rec_t eep_rec, // record
  output logic eep_ack, // done pulse
  output logic eep_err // failed
);
  logic [3:0] cnt;
  always_ff @(posedge sys_clk) begin
    eep_ack <= 1'b0;
    eep_err <= 1'b0;
    // record lines toggle outside the ack cycle so stale data never passes
    eep_rec <= rst ? '0 : ~eep_rec;
    if (rst) begin
      cnt <= 4'h0;
    end else if (eep_req && !eep_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= dly) begin
        cnt <= 4'h0;
        eep_ack <= 1'b1;
        eep_err <= eep_addr == err_idx;
        // plain configuration records only, nothing with side effects
        eep_rec <= {eep_addr == last_idx, eep_addr[7:0] | 8'h40, 32'hC0DE0000 | 32'(eep_addr)};
      end
    end
  end
endmodule // eep_model
`default_nettype wire

// ---- tb_fundamental_reset_init_sequencer.sv ----
// self-checking bench: boot straps, eeprom load, load error, halt pin, warm reset
// assumes the eeprom model answers within a few cycles
`timescale 1ns/1ps
`default_nettype none
module tb_fundamental_reset_init_sequencer;
  import fr_seq_pkg::*;
  logic sys_clk = 0, rst = 1, prn = 0, slow = 0, hpin = 0, wr = 0, rd = 0, rd_seen = 0;
  logic [3:0] mode = 0, dly = 0, taddr;
  logic [5:0] apins = 0;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [15:0] eaddr, div, last_idx = 0, err_idx = 16'hFFFF;
  logic req, ack, eerr, crn, trn, core, retry, run, warm, irq;
  eep_rec_t rec;
  cfg_wr_t cw;
  logic [39:0] rd_q[$], cfg_q[$];
  int fail_count = 0, cmp_count = 0;
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  fundamental_reset_init_sequencer #(.LOAD_CYC(50)) fundamental_reset_init_sequencer_inst (
    .sys_clk(sys_clk), .rst(rst), .bus_reset_input_n(prn), .operating_mode_pins(mode),
    .controller_bus_slow_select(slow), .target_bus_address_pins(apins), .reset_halt_pin(hpin),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .eep_req(req), .eep_addr(eaddr), .eep_rec(rec), .eep_ack(ack), .eep_err(eerr),
    .ctrl_bus_div(div), .ctrl_bus_rst_n(crn), .target_bus_rst_n(trn), .target_bus_addr(taddr),
    .cfg_wr(cw), .core_rst_n(core), .retry_mode(retry), .normal_op(run), .warm_reset(warm),
    .irq(irq));
  eep_model eep_model_inst (.sys_clk(sys_clk), .rst(rst), .eep_req(req), .eep_addr(eaddr),
    .dly(dly), .last_idx(last_idx), .err_idx(err_idx), .eep_rec(rec), .eep_ack(ack),
    .eep_err(eerr));
  // ----
  // checking and bus tasks
  // ----
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_on(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      @(posedge sys_clk);
      n++;
      if (n > 300) begin
        fail_count++;
        $display("[ERR] %0t wait ran out", $time);
        tally_and_finish();
      end
    end
  endtask
  // a gap cycle after each strobe keeps every driver to one assignment per step
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back({8'h00, exp});
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic boot(input logic [3:0] m, input logic s, input logic h);
    prn <= 1'b0;
    mode <= m;
    slow <= s;
    hpin <= h;
    apins <= 6'($urandom);
    dly <= 4'($urandom_range(3));
    repeat (3) @(posedge sys_clk);
    prn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(taddr, {apins[5], apins[3:1]});
    check(div, s ? 16'h03E8 : 16'h00FA);
  endtask
  always @(posedge sys_clk) begin
    if (rd_seen && rd_q.size() > 0) check({8'h00, rdata}, rd_q.pop_front());
    if (cw.valid === 1'b1) check({cw.addr, cw.data}, cfg_q.size() > 0 ? cfg_q.pop_front() : 'x);
    rd_seen <= rd;
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(19874));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    boot(4'h0, 1'b1, 1'b0);
    wait_on(run, 1'b1);
    rreg(OFS_STAT, 32'h0000_0006);
    rreg(OFS_INT_MASK, 32'(INT_MASK_RST));
    rreg(8'h40, 32'h0);
    $display("test plain boot done");
    last_idx <= 16'h0003;
    for (int i = 0; i < 4; i++) cfg_q.push_back({8'h40 | 8'(i), 32'hC0DE0000 | 32'(i)});
    boot(MODE_EEPROM, 1'b0, 1'b0);
    wait_on(run, 1'b1);
    check(40'(cfg_q.size()), 40'h0);
    rreg(OFS_BUS_STAT, 32'h0000_0401);
    rreg(OFS_INT_STAT, 32'h9);
    wreg(OFS_INT_MASK, 32'h1);
    check(irq, 1'b1);
    wreg(OFS_INT_STAT, 32'h1);
    check(irq, 1'b0);
    rreg(OFS_INT_STAT, 32'h8);
    $display("test eeprom load done");
    err_idx <= 16'h0002;
    for (int i = 0; i < 2; i++) cfg_q.push_back({8'h40 | 8'(i), 32'hC0DE0000 | 32'(i)});
    wreg(OFS_INT_MASK, 32'h2);
    boot(MODE_EEPROM, 1'b0, 1'b0);
    wait_on(irq, 1'b1);
    check({run, retry}, 2'b01);
    rreg(OFS_BUS_STAT, 32'h0000_0203);
    rreg(OFS_CTRL, 32'h1);
    wreg(OFS_EEP_WIN, 32'h8000_0005);
    repeat (12) @(posedge sys_clk);
    rreg(OFS_EEP_DATA, 32'hC0DE0005);
    rreg(OFS_EEP_WIN, 32'h0000_0005);
    wreg(OFS_CTRL, 32'h0);
    wait_on(run, 1'b1);
    check(40'(cfg_q.size()), 40'h0);
    $display("test load error done");
    err_idx <= 16'hFFFF;
    wreg(OFS_INT_STAT, 32'hF);
    wreg(OFS_INT_MASK, 32'h4);
    boot(4'h0, 1'b0, 1'b1);
    wait_on(irq, 1'b1);
    rreg(OFS_STAT, 32'h1);
    check(run, 1'b0);
    wreg(OFS_CTRL, 32'h0);
    wait_on(run, 1'b1);
    // new straps while the pin stays high must not be taken
    hpin <= 1'b0;
    slow <= 1'b1;
    apins <= ~apins;
    wreg(OFS_INT_STAT, 32'hF);
    wreg(OFS_CTRL, 32'h2);
    check(warm, 1'b0);
    wait_on(warm, 1'b1);
    wait_on(irq, 1'b1);
    rreg(OFS_STAT, 32'h1);
    rreg(OFS_CTRL, 32'h1);
    wreg(OFS_CTRL, 32'h0);
    wait_on(run, 1'b1);
    check(div, 16'h00FA);
    $display("test halt pin and warm reset done");
    // slowest eeprom answers: two records fit the 50-cycle budget, the third runs out
    for (int i = 0; i < 2; i++) cfg_q.push_back({8'h40 | 8'(i), 32'hC0DE0000 | 32'(i)});
    wreg(OFS_INT_STAT, 32'hF);
    wreg(OFS_INT_MASK, 32'h2);
    boot(MODE_EEPROM, 1'b0, 1'b0);
    dly <= 4'hF;
    wait_on(irq, 1'b1);
    check({run, retry}, 2'b01);
    rreg(OFS_BUS_STAT, 32'h0000_0205);
    rreg(OFS_CTRL, 32'h1);
    wreg(OFS_CTRL, 32'h0);
    wait_on(run, 1'b1);
    check(40'(cfg_q.size()), 40'h0);
    $display("test load timeout done");
    tally_and_finish();
  end
endmodule // tb_fundamental_reset_init_sequencer
`default_nettype wire
